// *** verilog/lan_pwr_dbg_pkg.sv ***
// Constants, field positions and state type for the LAN power and debug control block
package lan_pwr_dbg_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [19:0] NVM_EXT_OFF = 20'h00040;
   localparam logic [19:0] FUTURE_EXT_OFF = 20'h0002C;
   localparam logic [19:0] IRQ_STAT_OFF = 20'h00044;
   localparam logic [19:0] IRQ_MASK_OFF = 20'h00048;
   // ----------------------------------------------------------------
   // NVM extension register, stored bits 31:23
   // ----------------------------------------------------------------
   localparam int NVM_LO = 23;
   localparam int NVM_W = 9;
   localparam int PHY_PERMIT_BIT = 27;
   localparam int PD_WOL_EN_BIT = 30;
   localparam int PD_D3_EN_BIT = 31;
   localparam logic [8:0] NVM_RST = 9'h000;
   // ----------------------------------------------------------------
   // Future extension control register, stored bits 31:4
   // ----------------------------------------------------------------
   localparam int FUTURE_EXTENSION_CONTROL_LO = 4;
   localparam int FUTURE_EXTENSION_CONTROL_W = 28;
   localparam int EXT_PWR_BIT = 3;
   localparam int CRC_TRIG_EN_BIT = 8;
   localparam int CRC_WR_BLOCK_BIT = 9;
   localparam int OBS_EN_BIT = 10;
   localparam int OBS_IN_SEL_BIT = 11;
   localparam int OBS_DATA_SEL_BIT = 12;
   localparam int GHOST_RD_EN_BIT = 13;
   localparam int FUT_LO = 18;
   localparam logic [27:0] FUTURE_EXTENSION_CONTROL_RST = 28'h0000000;
   // ----------------------------------------------------------------
   // Interrupt status and mask layout
   // ----------------------------------------------------------------
   localparam int EV_W = 3;
   localparam int EV_CRC_BIT = 0;
   localparam int EV_BLOCK_BIT = 1;
   localparam int EV_PWR_BIT = 2;
   localparam logic [2:0] EV_RST = 3'h0;
   localparam logic [31:0] WORD_ZERO = 32'h00000000;

   typedef struct packed {
      logic [8:0] nvm_hi;
      logic [27:0] future_extension_control_hi;
      logic [2:0] stat;
      logic [2:0] mask;
      logic pwr_q;
      logic primed;
      logic [31:0] rd_data;
      logic irq;
      logic pd_ready;
      logic trig;
      logic wr_block;
      logic obs_valid;
      logic [31:0] obs_data;
      logic ghost_rd_en;
   } state_t;

   localparam state_t STATE_RST = '{
      nvm_hi: NVM_RST, future_extension_control_hi: FUTURE_EXTENSION_CONTROL_RST, stat: EV_RST, mask: EV_RST,
      pwr_q: 1'b0, primed: 1'b0, rd_data: WORD_ZERO, irq: 1'b0,
      pd_ready: 1'b0, trig: 1'b0, wr_block: 1'b0, obs_valid: 1'b0,
      obs_data: WORD_ZERO, ghost_rd_en: 1'b0};
endpackage

// *** verilog/lan_pwr_dbg_ctrl.sv ***
// Control and status register bank for LAN power-down and CRC debug features
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Bit 27 permit is storage only
// - Bit 30 gates power-down-ready under wake-on-LAN
// - Bit 31 gates power-down-ready in D3/no-wake
// - Register resets only on power-good reset
// - Bit 3 reports external power state
// - Bit 8 pulses trigger on CRC mismatch
// - Trigger suppressed while CRC is offloaded
// - Bit 9 blocks RAM writes after mismatch
// - Bit 10 routes ghost RAMs to observation
// - Bit 11 selects inbound or outbound data
// - Bit 12 selects data or descriptor RAM
// - Bit 13 permits ghost RAM bus reads
// - Bits 31:18 writable storage reset zero
module lan_pwr_dbg_ctrl
   import lan_pwr_dbg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [19:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output var logic [31:0] rd_data,
   output var logic irq,
   input wire logic ext_power_on,
   input wire logic wol_cfg,
   input wire logic d3_nowake_cfg,
   input wire logic pd_ready_req,
   output var logic powerdown_ready,
   input wire logic frame_done,
   input wire logic [31:0] sw_crc,
   input wire logic [31:0] hw_crc,
   input wire logic crc_offload,
   output var logic crc_mismatch_trig,
   output var logic ram_write_block,
   input wire logic [31:0] ghost_desc_in,
   input wire logic [31:0] ghost_desc_out,
   input wire logic [31:0] ghost_data_in,
   input wire logic [31:0] ghost_data_out,
   output var logic obs_valid,
   output var logic [31:0] observation_port,
   output var logic ghost_read_en
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [19:0] a, input logic [19:0] off);
      hit = (a == off);
   endfunction

   state_t st_r;
   state_t st_nxt;
   logic mismatch;
   logic [31:0] nvm_word;
   logic [31:0] future_extension_control_word;

   assign mismatch = frame_done && (sw_crc != hw_crc);
   assign nvm_word = {st_r.nvm_hi, 23'h000000};
   // Low three bits are hardwired zero
   assign future_extension_control_word = {st_r.future_extension_control_hi, ext_power_on, 3'h0};

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [2:0] ev;
      logic [31:0] fx;
      logic [31:0] nv;
      logic allow;
      ev = 3'h0;
      fx = 32'h00000000;
      nv = 32'h00000000;
      allow = 1'b0;
      st_nxt = st_r;
      nv = nvm_word;
      fx = future_extension_control_word;

      // Register writes; bit 27 and bits 31:18 only stored
      if (wr_en)
      begin
         if (hit(addr, NVM_EXT_OFF))
         begin
            st_nxt.nvm_hi = wr_data[31:NVM_LO];
         end
         else if (hit(addr, FUTURE_EXT_OFF))
         begin
            st_nxt.future_extension_control_hi = wr_data[31:FUTURE_EXTENSION_CONTROL_LO];
         end
         else if (hit(addr, IRQ_MASK_OFF))
         begin
            st_nxt.mask = wr_data[EV_W-1:0];
         end
      end

      // Read data stands one cycle only
      st_nxt.rd_data = WORD_ZERO;
      if (rd_en)
      begin
         if (hit(addr, NVM_EXT_OFF))
         begin
            st_nxt.rd_data = nv;
         end
         else if (hit(addr, FUTURE_EXT_OFF))
         begin
            st_nxt.rd_data = fx;
         end
         else if (hit(addr, IRQ_STAT_OFF))
         begin
            st_nxt.rd_data = {29'h00000000, st_r.stat};
         end
         else if (hit(addr, IRQ_MASK_OFF))
         begin
            st_nxt.rd_data = {29'h00000000, st_r.mask};
         end
      end

      // CRC mismatch trigger and write block
      st_nxt.trig = mismatch && fx[CRC_TRIG_EN_BIT] && !crc_offload;
      if (mismatch && fx[CRC_WR_BLOCK_BIT])
      begin
         st_nxt.wr_block = 1'b1;
      end

      // Power-down-ready gating
      allow = 1'b1;
      if (wol_cfg)
      begin
         allow = nv[PD_WOL_EN_BIT];
      end
      else if (d3_nowake_cfg)
      begin
         allow = nv[PD_D3_EN_BIT];
      end
      st_nxt.pd_ready = pd_ready_req && allow;

      // Observation port routing
      st_nxt.obs_valid = fx[OBS_EN_BIT];
      st_nxt.obs_data = WORD_ZERO;
      if (fx[OBS_EN_BIT])
      begin
         if (fx[OBS_DATA_SEL_BIT])
         begin
            st_nxt.obs_data = fx[OBS_IN_SEL_BIT] ? ghost_data_in : ghost_data_out;
         end
         else
         begin
            st_nxt.obs_data = fx[OBS_IN_SEL_BIT] ? ghost_desc_in : ghost_desc_out;
         end
      end
      st_nxt.ghost_rd_en = fx[GHOST_RD_EN_BIT];

      // Sticky events; set wins over read-clear
      st_nxt.pwr_q = ext_power_on;
      st_nxt.primed = 1'b1;
      ev[EV_CRC_BIT] = mismatch;
      ev[EV_BLOCK_BIT] = mismatch && fx[CRC_WR_BLOCK_BIT] && !st_r.wr_block;
      ev[EV_PWR_BIT] = st_r.primed && (ext_power_on != st_r.pwr_q);
      if (rd_en && hit(addr, IRQ_STAT_OFF))
      begin
         st_nxt.stat = ev;
      end
      else
      begin
         st_nxt.stat = st_r.stat | ev;
      end
      st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
   end

   // ----------------------------------------------------------------
   // State register, power-good reset only
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r <= STATE_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign rd_data = st_r.rd_data;
   assign irq = st_r.irq;
   assign powerdown_ready = st_r.pd_ready;
   assign crc_mismatch_trig = st_r.trig;
   assign ram_write_block = st_r.wr_block;
   assign obs_valid = st_r.obs_valid;
   assign observation_port = st_r.obs_data;
   assign ghost_read_en = st_r.ghost_rd_en;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_trig_fires;
      @(posedge sys_clk) disable iff (!rst_b)
      (frame_done && (sw_crc != hw_crc) && st_r.future_extension_control_hi[CRC_TRIG_EN_BIT-FUTURE_EXTENSION_CONTROL_LO] && !crc_offload)
      |=> crc_mismatch_trig ##1 !crc_mismatch_trig || $past(mismatch);
   endproperty
   a_trig_fires: assert property (p_trig_fires) else $error("mismatch trigger missing");

   property p_trig_offload;
      @(posedge sys_clk) disable iff (!rst_b)
      crc_offload |=> !crc_mismatch_trig;
   endproperty
   a_trig_offload: assert property (p_trig_offload) else $error("trigger while offloaded");

   property p_block_sets;
      @(posedge sys_clk) disable iff (!rst_b)
      (mismatch && st_r.future_extension_control_hi[CRC_WR_BLOCK_BIT-FUTURE_EXTENSION_CONTROL_LO]) |=> ram_write_block [*4];
   endproperty
   a_block_sets: assert property (p_block_sets) else $error("write block not held");

   property p_block_cause;
      @(posedge sys_clk) disable iff (!rst_b)
      $rose(ram_write_block) |-> $past(mismatch) && $past(st_r.future_extension_control_hi[CRC_WR_BLOCK_BIT-FUTURE_EXTENSION_CONTROL_LO]);
   endproperty
   a_block_cause: assert property (p_block_cause) else $error("write block without cause");

   property p_pd_wol;
      @(posedge sys_clk) disable iff (!rst_b)
      (wol_cfg && !st_r.nvm_hi[PD_WOL_EN_BIT-NVM_LO]) |=> !powerdown_ready;
   endproperty
   a_pd_wol: assert property (p_pd_wol) else $error("ready under wake-on-LAN");

   property p_pd_d3;
      @(posedge sys_clk) disable iff (!rst_b)
      (!wol_cfg && d3_nowake_cfg && pd_ready_req && st_r.nvm_hi[PD_D3_EN_BIT-NVM_LO]) |=> powerdown_ready;
   endproperty
   a_pd_d3: assert property (p_pd_d3) else $error("ready missing in D3");

   property p_pwr_read;
      @(posedge sys_clk) disable iff (!rst_b)
      (rd_en && addr == FUTURE_EXT_OFF) |=> rd_data[EXT_PWR_BIT] == $past(ext_power_on) && rd_data[2:0] == 3'h0;
   endproperty
   a_pwr_read: assert property (p_pwr_read) else $error("power bit or low bits wrong");

   property p_obs_sel;
      @(posedge sys_clk) disable iff (!rst_b)
      (st_r.future_extension_control_hi[OBS_EN_BIT-FUTURE_EXTENSION_CONTROL_LO] && st_r.future_extension_control_hi[OBS_DATA_SEL_BIT-FUTURE_EXTENSION_CONTROL_LO]
       && st_r.future_extension_control_hi[OBS_IN_SEL_BIT-FUTURE_EXTENSION_CONTROL_LO]) |=> obs_valid && observation_port == $past(ghost_data_in);
   endproperty
   a_obs_sel: assert property (p_obs_sel) else $error("observation select wrong");

   property p_ghost_rd;
      @(posedge sys_clk) disable iff (!rst_b)
      ##1 ghost_read_en == $past(st_r.future_extension_control_hi[GHOST_RD_EN_BIT-FUTURE_EXTENSION_CONTROL_LO]);
   endproperty
   a_ghost_rd: assert property (p_ghost_rd) else $error("ghost read enable wrong");

   property p_fut_store;
      @(posedge sys_clk) disable iff (!rst_b)
      (wr_en && addr == FUTURE_EXT_OFF) ##1 (rd_en && addr == FUTURE_EXT_OFF)
      |=> rd_data[31:FUT_LO] == $past(wr_data[31:FUT_LO], 2);
   endproperty
   a_fut_store: assert property (p_fut_store) else $error("upper bits not stored");

   property p_trig_cause;
      @(posedge sys_clk) disable iff (!rst_b)
      crc_mismatch_trig |-> $past(mismatch) && !$past(crc_offload)
         && $past(st_r.future_extension_control_hi[CRC_TRIG_EN_BIT-FUTURE_EXTENSION_CONTROL_LO]);
   endproperty
   a_trig_cause: assert property (p_trig_cause) else $error("trigger without enabled mismatch");

   property p_block_sticky;
      @(posedge sys_clk) disable iff (!rst_b)
      ram_write_block |=> ram_write_block;
   endproperty
   a_block_sticky: assert property (p_block_sticky) else $error("write block released");

   property p_obs_off;
      @(posedge sys_clk) disable iff (!rst_b)
      !st_r.future_extension_control_hi[OBS_EN_BIT-FUTURE_EXTENSION_CONTROL_LO] |=> !obs_valid && observation_port == WORD_ZERO;
   endproperty
   a_obs_off: assert property (p_obs_off) else $error("observation port active while off");

   property p_obs_desc_out;
      @(posedge sys_clk) disable iff (!rst_b)
      (st_r.future_extension_control_hi[OBS_EN_BIT-FUTURE_EXTENSION_CONTROL_LO] && !st_r.future_extension_control_hi[OBS_DATA_SEL_BIT-FUTURE_EXTENSION_CONTROL_LO]
       && !st_r.future_extension_control_hi[OBS_IN_SEL_BIT-FUTURE_EXTENSION_CONTROL_LO]) |=> obs_valid && observation_port == $past(ghost_desc_out);
   endproperty
   a_obs_desc_out: assert property (p_obs_desc_out) else $error("outbound descriptor not observed");

   property p_pd_d3_off;
      @(posedge sys_clk) disable iff (!rst_b)
      (!wol_cfg && d3_nowake_cfg && !st_r.nvm_hi[PD_D3_EN_BIT-NVM_LO]) |=> !powerdown_ready;
   endproperty
   a_pd_d3_off: assert property (p_pd_d3_off) else $error("ready in D3 while disabled");

   property p_nvm_store;
      @(posedge sys_clk) disable iff (!rst_b)
      (wr_en && addr == NVM_EXT_OFF) |=> st_r.nvm_hi == $past(wr_data[31:NVM_LO]);
   endproperty
   a_nvm_store: assert property (p_nvm_store) else $error("extension bits not stored");

endmodule
`default_nettype wire

// *** test/lan_pwr_dbg_ctrl_tb_top.sv ***
// Self-checking testbench for the LAN power and debug control block
`timescale 1ns/1ps
`default_nettype none
module lan_pwr_dbg_ctrl_tb_top;
   import lan_pwr_dbg_pkg::*;
   logic sys_clk = 1'h0;
   logic rst_b = 1'h0;
   logic [19:0] addr = 20'h00000;
   logic [31:0] wr_data = 32'h00000000;
   logic wr_en = 1'h0;
   logic rd_en = 1'h0;
   logic ext_power_on = 1'h1;
   logic wol_cfg = 1'h0;
   logic d3_nowake_cfg = 1'h0;
   logic pd_ready_req = 1'h0;
   logic frame_done = 1'h0;
   logic [31:0] sw_crc = 32'h00000000;
   logic [31:0] hw_crc = 32'h00000000;
   logic crc_offload = 1'h0;
   logic [31:0] ghost [4] = '{32'hD0D0D0D0, 32'hD1D1D1D1, 32'hA0A0A0A0, 32'hA1A1A1A1};
   logic [31:0] rd_data;
   logic [31:0] observation_port;
   logic irq, powerdown_ready, crc_mismatch_trig, ram_write_block, obs_valid, ghost_read_en;
   int fail_count = 0;
   int num_checks = 0;

   always #2 sys_clk = ~sys_clk;

   lan_pwr_dbg_ctrl i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .ext_power_on(ext_power_on), .wol_cfg(wol_cfg),
      .d3_nowake_cfg(d3_nowake_cfg), .pd_ready_req(pd_ready_req), .powerdown_ready(powerdown_ready),
      .frame_done(frame_done), .sw_crc(sw_crc), .hw_crc(hw_crc), .crc_offload(crc_offload),
      .crc_mismatch_trig(crc_mismatch_trig), .ram_write_block(ram_write_block), .ghost_desc_in(ghost[1]),
      .ghost_desc_out(ghost[0]), .ghost_data_in(ghost[3]), .ghost_data_out(ghost[2]), .obs_valid(obs_valid),
      .observation_port(observation_port), .ghost_read_en(ghost_read_en));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
      begin
         $display("Finished cleanly");
      end
      else
      begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic bus_wr(input logic [19:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr_en <= 1'h1;
      addr <= a;
      wr_data <= d;
      @(posedge sys_clk);
      wr_en <= 1'h0;
   endtask

   task automatic bus_rd(input logic [19:0] a, input logic [31:0] exp, input string name);
      @(posedge sys_clk);
      rd_en <= 1'h1;
      addr <= a;
      @(posedge sys_clk);
      rd_en <= 1'h0;
      #1;
      check(name, rd_data, exp);
   endtask

   // Write then read with no gap between the strobes
   task automatic bus_wr_rd(input logic [19:0] a, input logic [31:0] d, input logic [31:0] exp, input string name);
      @(posedge sys_clk);
      wr_en <= 1'h1;
      addr <= a;
      wr_data <= d;
      @(posedge sys_clk);
      wr_en <= 1'h0;
      rd_en <= 1'h1;
      @(posedge sys_clk);
      rd_en <= 1'h0;
      #1;
      check(name, rd_data, exp);
   endtask

   task automatic frame(input logic [31:0] s, input logic o, input logic t, input logic b);
      @(posedge sys_clk);
      frame_done <= 1'h1;
      sw_crc <= s;
      hw_crc <= 32'h12345678;
      crc_offload <= o;
      @(posedge sys_clk);
      frame_done <= 1'h0;
      #1;
      check("trigger", {31'h0, crc_mismatch_trig}, {31'h0, t});
      check("write block", {31'h0, ram_write_block}, {31'h0, b});
   endtask

   task automatic pd_case(input logic w, input logic d, input logic [31:0] nvm, input logic e);
      bus_wr(NVM_EXT_OFF, nvm);
      @(posedge sys_clk);
      wol_cfg <= w;
      d3_nowake_cfg <= d;
      tick(3);
      check("powerdown ready", {31'h0, powerdown_ready}, {31'h0, e});
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      bus_rd(FUTURE_EXT_OFF, 32'h00000008, "future_extension_control reset");
      bus_rd(NVM_EXT_OFF, 32'h00000000, "nvm reset");
      bus_wr_rd(FUTURE_EXT_OFF, 32'hFFFFFFFF, 32'hFFFFFFF8, "future_extension_control all ones");
      @(posedge sys_clk);
      ext_power_on <= 1'h0;
      tick(2);
      bus_rd(FUTURE_EXT_OFF, 32'hFFFFFFF0, "power off");
      bus_wr(FUTURE_EXT_OFF, 32'h00000000);
      bus_wr(NVM_EXT_OFF, 32'hFFFFFFFF);
      bus_rd(NVM_EXT_OFF, 32'hFF800000, "nvm all ones");
      tick(1);
      check("read idle", rd_data, 32'h00000000);
      bus_rd(20'h00100, 32'h00000000, "unmapped");
      @(posedge sys_clk);
      ext_power_on <= 1'h1;
      $display("register test done");
   endtask

   task automatic t_power();
      @(posedge sys_clk);
      pd_ready_req <= 1'h1;
      pd_case(1'h0, 1'h0, 32'h00000000, 1'h1);
      pd_case(1'h1, 1'h0, 32'h00000000, 1'h0);
      pd_case(1'h1, 1'h0, 32'h40000000, 1'h1);
      pd_case(1'h0, 1'h1, 32'h40000000, 1'h0);
      pd_case(1'h0, 1'h1, 32'h88000000, 1'h1);
      $display("power test done");
   endtask

   task automatic t_crc();
      bus_rd(IRQ_STAT_OFF, 32'h00000004, "power event");
      bus_wr(IRQ_MASK_OFF, 32'h00000003);
      bus_rd(IRQ_MASK_OFF, 32'h00000003, "mask");
      bus_wr(FUTURE_EXT_OFF, 32'h00000100);
      frame(32'h12345679, 1'h0, 1'h1, 1'h0);
      frame(32'h12345679, 1'h1, 1'h0, 1'h0);
      frame(32'h12345678, 1'h0, 1'h0, 1'h0);
      tick(1);
      check("irq set", {31'h0, irq}, 32'h00000001);
      bus_rd(IRQ_STAT_OFF, 32'h00000001, "status");
      tick(2);
      check("irq clear", {31'h0, irq}, 32'h00000000);
      bus_wr(FUTURE_EXT_OFF, 32'h00000200);
      frame(32'h00000000, 1'h1, 1'h0, 1'h1);
      bus_wr(FUTURE_EXT_OFF, 32'h00000000);
      tick(2);
      check("block sticky", {31'h0, ram_write_block}, 32'h00000001);
      bus_rd(IRQ_STAT_OFF, 32'h00000003, "status block");
      bus_wr(IRQ_MASK_OFF, 32'h00000000);
      frame(32'h00000000, 1'h0, 1'h0, 1'h1);
      tick(2);
      check("irq masked", {31'h0, irq}, 32'h00000000);
      $display("crc test done");
   endtask

   task automatic t_obs();
      for (int s = 0; s < 4; s++)
      begin
         bus_wr(FUTURE_EXT_OFF, 32'h00002400 | (32'(s) << 11));
         tick(2);
         check("obs valid", {31'h0, obs_valid}, 32'h00000001);
         check("obs data", observation_port, ghost[s]);
         check("ghost read", {31'h0, ghost_read_en}, 32'h00000001);
      end
      bus_wr(FUTURE_EXT_OFF, 32'h00001800);
      tick(2);
      check("obs off", {31'h0, obs_valid}, 32'h00000000);
      check("obs data off", observation_port, 32'h00000000);
      check("ghost off", {31'h0, ghost_read_en}, 32'h00000000);
      $display("observation test done");
   endtask

   task automatic t_reset();
      @(posedge sys_clk);
      rst_b <= 1'h0;
      tick(1);
      check("block in reset", {31'h0, ram_write_block}, 32'h00000000);
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'h1;
      tick(1);
      check("block after reset", {31'h0, ram_write_block}, 32'h00000000);
      check("powerdown after reset", {31'h0, powerdown_ready}, 32'h00000000);
      bus_rd(FUTURE_EXT_OFF, 32'h00000008, "future_extension_control after reset");
      bus_rd(NVM_EXT_OFF, 32'h00000000, "nvm after reset");
      $display("reset test done");
   endtask

   initial
   begin
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'h1;
      t_regs();
      t_power();
      t_crc();
      t_obs();
      t_reset();
      finish_test();
   end

   initial
   begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      $display("unexpected run length limit reached");
      finish_test();
   end
endmodule
`default_nettype wire
